// *** inc/rpb_regs.svh ***
`ifndef RPB_REGS_SVH
`define RPB_REGS_SVH
// ********************************************************************
// host command opcodes (first byte of every frame)
// ********************************************************************
`define RPB_OP_WRBUF   8'h10
`define RPB_OP_RDBUF   8'h20
`define RPB_OP_SETBASE 8'h30
`define RPB_OP_RXSTAT  8'h40
`define RPB_OP_PKTLEN  8'h50
// ********************************************************************
// reset values and buffer geometry
// ********************************************************************
`define RPB_BASE_RST   8'h00
`define RPB_ZERO8      8'h00
`define RPB_LAST8      8'hff
`define RPB_RAM_WORDS  256
// byte position inside a frame
`define RPB_IDX_OP     2'h0
`define RPB_IDX_P1     2'h1
`define RPB_IDX_P2     2'h2
`define RPB_IDX_MAX    2'h3
`define RPB_BIT_LAST   3'h7
`define RPB_BIT_FIRST  3'h0
// ********************************************************************
// timing
// ********************************************************************
`define RPB_SYS_NS     100
`define RPB_HRST_NS    100000
// least low time on the hardware reset pin, rounded up
`define RPB_HRST_CYC   ((`RPB_HRST_NS + `RPB_SYS_NS - 1) / `RPB_SYS_NS)
// longest delay from frame end to busy rising, rounded down
`define RPB_TSW_NS     600
`define RPB_TSW_CYC    (`RPB_TSW_NS / `RPB_SYS_NS)
// busy hold after a write command
`define RPB_BUSY_HOLD  4'h4
// calibration length after wake or reset
`define RPB_INIT_CYC   16'h0040
`endif

// *** inc/rpb_pkg.sv ***
package rpb_pkg;
	// operating modes, gray along clear-init-standby-rx-tx-sleep
	typedef enum logic [2:0] {
		M_CLEAR = 3'h0,
		M_INIT  = 3'h1,
		M_STBY  = 3'h3,
		M_RX    = 3'h2,
		M_TX    = 3'h6,
		M_SLEEP = 3'h4
	} rpb_mode_t;

	// one-cycle mode requests from the radio controller
	typedef struct packed {
		logic sleep;
		logic stby;
		logic tx;
		logic rx_single;
		logic rx_cont;
	} rpb_mode_req_t;

	// internal-clock state
	typedef struct packed {
		rpb_mode_t   mode;
		logic        go_init;
		logic [7:0]  clr_addr;
		logic [15:0] init_cnt;
		logic [10:0] hrst_cnt;
		logic        hrst_done;
		logic [3:0]  busy_cnt;
		logic        busy;
		logic        oe_n;
		logic        cs_s1, cs_s2, cs_s3;
		logic        hr_s1, hr_s2;
		logic        tg_s1, tg_s2, tg_s3;
		logic [7:0]  op;
		logic [1:0]  idx;
		logic [7:0]  acc_ptr;
		logic [7:0]  pub;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [7:0]  wr_data;
		logic [7:0]  tx_base;
		logic [7:0]  rx_base;
		logic [7:0]  plen;
		logic [7:0]  rx_ptr;
		logic        pkt_first;
		logic [7:0]  pkt_start;
		logic [7:0]  pkt_len;
		logic [7:0]  last_start;
		logic [7:0]  last_len;
		logic [7:0]  tx_ptr;
		logic [7:0]  tx_cnt;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic        tx_done;
	} rpb_sys_t;

	// link-clock rising edge, cleared by chip select
	typedef struct packed {
		logic [2:0] bitc;
		logic [6:0] sh;
	} rpb_frame_t;

	// completed byte and its toggle, kept across frames
	typedef struct packed {
		logic [7:0] rx_byte;
		logic       tgl;
	} rpb_link_t;

	// link-clock falling edge output shifter
	typedef struct packed {
		logic [7:0] sh;
	} rpb_fall_t;
endpackage

// *** verilog/rpb_top.sv ***
`timescale 1ns/1ns
`include "rpb_regs.svh"
module rpb_top #(
	parameter logic [15:0] INIT_CYC = `RPB_INIT_CYC
) (
	// system
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// host serial link
	input  wire logic                  sck,
	input  wire logic                  chip_select_n,
	input  wire logic                  mosi,
	output wire logic                  miso,
	output wire logic                  miso_oe_n,
	output wire logic                  busy,
	// hardware reset pin
	input  wire logic                  hardware_reset_n,
	// radio controller side
	input  wire rpb_pkg::rpb_mode_req_t mode_req,
	input  wire logic                  rx_valid,
	input  wire logic [7:0]            rx_data,
	input  wire logic                  rx_end,
	input  wire logic                  tx_req,
	output wire logic                  tx_valid,
	output wire logic [7:0]            tx_data,
	output wire logic                  tx_done,
	output wire rpb_pkg::rpb_mode_t    mode_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// eight-bit pointer step, wraps past the last location
	function automatic logic [7:0] inc8(input logic [7:0] p);
		return 8'(p + 8'h01);
	endfunction

	function automatic logic awake(input rpb_pkg::rpb_mode_t m);
		return (m == rpb_pkg::M_STBY) || (m == rpb_pkg::M_RX) ||
			(m == rpb_pkg::M_TX);
	endfunction

	function automatic logic is_wr_op(input logic [7:0] op);
		return (op == `RPB_OP_WRBUF) || (op == `RPB_OP_SETBASE) ||
			(op == `RPB_OP_PKTLEN);
	endfunction

	localparam rpb_pkg::rpb_sys_t SYS_RST = '{
		mode: rpb_pkg::M_CLEAR, go_init: 1'b1, busy: 1'b1,
		oe_n: 1'b1, cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
		hr_s1: 1'b1, hr_s2: 1'b1, pkt_first: 1'b1, default: '0};

	rpb_pkg::rpb_sys_t   s_q, s_d;
	rpb_pkg::rpb_frame_t fr_q, fr_d;
	rpb_pkg::rpb_link_t  lk_q, lk_d;
	rpb_pkg::rpb_fall_t  fa_q, fa_d;
	logic [7:0]          ram [`RPB_RAM_WORDS];
	logic                ram_we;
	logic [7:0]          ram_wa;
	logic [7:0]          ram_wd;
	logic                hrst_hit;
	logic                rx_wr;

	// ****************************************************************
	// link clock domain
	// ****************************************************************
	// shift in on rising edges, mode zero slave only
	always_comb begin
		fr_d = fr_q;
		lk_d = lk_q;
		fr_d.sh = {fr_q.sh[5:0], mosi};
		fr_d.bitc = 3'(fr_q.bitc + 3'h1);
		if (fr_q.bitc == `RPB_BIT_LAST) begin
			lk_d.rx_byte = {fr_q.sh, mosi};
			lk_d.tgl = ~lk_q.tgl;
		end
	end

	// frame logic is cleared by chip select high
	always_ff @(posedge sck or posedge chip_select_n) begin
		if (chip_select_n) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// toggle must survive frame ends or the far side sees a false byte
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// reply byte is loaded at each byte boundary, then shifted
	always_comb begin
		fa_d = fa_q;
		if (fr_q.bitc == `RPB_BIT_FIRST) begin
			fa_d.sh = s_q.pub;
		end else begin
			fa_d.sh = {fa_q.sh[6:0], 1'b0};
		end
	end

	// pub is quasi-static: it changes only well after a byte boundary
	always_ff @(negedge sck or posedge chip_select_n) begin
		if (chip_select_n) begin
			fa_q <= '0;
		end else begin
			fa_q <= fa_d;
		end
	end

	// ****************************************************************
	// internal clock domain
	// ****************************************************************
	// mode, pointers, command decode and ram write port
	always_comb begin
		logic [7:0] b;
		logic       new_byte;
		logic       cs_fall;
		logic       cs_rise;
		logic [7:0] len_n;
		rpb_pkg::rpb_sys_t keep;
		s_d = s_q;
		keep = s_q;
		ram_we = 1'b0;
		ram_wa = `RPB_ZERO8;
		ram_wd = `RPB_ZERO8;
		hrst_hit = 1'b0;
		rx_wr = 1'b0;
		len_n = s_q.pkt_len;
		b = lk_q.rx_byte;
		new_byte = s_q.tg_s3 ^ s_q.tg_s2;
		cs_fall = s_q.cs_s3 & ~s_q.cs_s2;
		cs_rise = ~s_q.cs_s3 & s_q.cs_s2;
		s_d.cs_s1 = chip_select_n;
		s_d.cs_s2 = s_q.cs_s1;
		s_d.cs_s3 = s_q.cs_s2;
		s_d.hr_s1 = hardware_reset_n;
		s_d.hr_s2 = s_q.hr_s1;
		s_d.tg_s1 = lk_q.tgl;
		s_d.tg_s2 = s_q.tg_s1;
		s_d.tg_s3 = s_q.tg_s2;
		s_d.tx_valid = 1'b0;
		s_d.oe_n = s_q.cs_s2; // float output outside frames
		if (s_q.busy_cnt != 4'h0) begin
			s_d.busy_cnt = 4'(s_q.busy_cnt - 4'h1);
		end
		// low time on the reset pin is measured before acting
		if (s_q.hr_s2) begin
			s_d.hrst_cnt = 11'h000;
			s_d.hrst_done = 1'b0;
		end else if (!s_q.hrst_done) begin
			if (s_q.hrst_cnt == 11'(`RPB_HRST_CYC - 1)) begin
				hrst_hit = 1'b1;
			end else begin
				s_d.hrst_cnt = 11'(s_q.hrst_cnt + 11'h001);
			end
		end
		case (s_q.mode)
			// wipe the buffer; busy stays high meanwhile
			rpb_pkg::M_CLEAR: begin
				ram_we = 1'b1;
				ram_wa = s_q.clr_addr;
				s_d.clr_addr = inc8(s_q.clr_addr);
				if (s_q.clr_addr == `RPB_LAST8) begin
					s_d.mode = s_q.go_init ? rpb_pkg::M_INIT :
						rpb_pkg::M_SLEEP;
					s_d.init_cnt = 16'h0000;
				end
			end
			// calibration, then standby releases busy
			rpb_pkg::M_INIT: begin
				s_d.init_cnt = 16'(s_q.init_cnt + 16'h0001);
				if (s_q.init_cnt == 16'(INIT_CYC - 16'h0001)) begin
					s_d.mode = rpb_pkg::M_STBY;
				end
			end
			// only a chip select falling edge or a hardware reset wakes the block
			rpb_pkg::M_SLEEP: begin
				if (cs_fall) begin
					s_d.mode = rpb_pkg::M_INIT;
					s_d.init_cnt = 16'h0000;
					// the waking frame may carry a command: start it clean
					s_d.idx = `RPB_IDX_OP;
					s_d.op = `RPB_ZERO8;
					s_d.pub = `RPB_ZERO8;
				end
			end
			rpb_pkg::M_STBY, rpb_pkg::M_RX, rpb_pkg::M_TX: begin
				// mode entry, sleep first
				if (mode_req.sleep) begin
					s_d.mode = rpb_pkg::M_CLEAR;
					s_d.go_init = 1'b0;
					s_d.clr_addr = `RPB_ZERO8;
				end else if (mode_req.stby) begin
					s_d.mode = rpb_pkg::M_STBY;
				end else if (mode_req.tx) begin
					s_d.mode = rpb_pkg::M_TX;
					s_d.tx_ptr = s_q.tx_base;
					s_d.tx_cnt = `RPB_ZERO8;
					s_d.tx_done = 1'b0;
				end else if (mode_req.rx_single) begin
					s_d.mode = rpb_pkg::M_RX;
					s_d.rx_ptr = s_q.rx_base;
					s_d.pkt_first = 1'b1;
				end else if (mode_req.rx_cont) begin
					s_d.mode = rpb_pkg::M_RX; // keeps rx_ptr
					s_d.pkt_first = 1'b1;
				end
				// store every byte, checksum never consulted
				if (s_q.mode == rpb_pkg::M_RX && rx_valid) begin
					rx_wr = 1'b1;
					ram_we = 1'b1;
					ram_wa = s_q.rx_ptr;
					ram_wd = rx_data;
					// no limit: overruns the transmit area
					s_d.rx_ptr = inc8(s_q.rx_ptr);
					s_d.pkt_first = 1'b0;
					if (s_q.pkt_first) begin
						s_d.pkt_start = s_q.rx_ptr;
						len_n = 8'h01;
					end else begin
						len_n = inc8(s_q.pkt_len);
					end
					s_d.pkt_len = len_n;
				end
				if (s_q.mode == rpb_pkg::M_RX && rx_end) begin
					s_d.last_start = rx_wr && s_q.pkt_first ?
						s_q.rx_ptr : s_q.pkt_start;
					s_d.last_len = len_n;
					s_d.pkt_first = 1'b1;
				end
				// send until the count meets the payload length
				if (s_q.mode == rpb_pkg::M_TX && tx_req) begin
					if (s_q.tx_cnt == s_q.plen) begin
						s_d.tx_done = 1'b1;
					end else begin
						s_d.tx_valid = 1'b1;
						s_d.tx_data = ram[s_q.tx_ptr];
						s_d.tx_ptr = inc8(s_q.tx_ptr);
						s_d.tx_cnt = inc8(s_q.tx_cnt);
					end
				end
				// host write waits while receive owns the port
				if (!rx_wr && s_q.wr_pend) begin
					ram_we = 1'b1;
					ram_wa = s_q.wr_addr;
					ram_wd = s_q.wr_data;
					s_d.wr_pend = 1'b0;
				end
				// no wake delay when awake
				if (cs_fall) begin
					s_d.idx = `RPB_IDX_OP;
					s_d.op = `RPB_ZERO8;
					s_d.pub = `RPB_ZERO8;
				end
				// opcode, then offset or parameters, then data
				if (new_byte) begin
					if (s_q.idx != `RPB_IDX_MAX) begin
						s_d.idx = 2'(s_q.idx + 2'h1);
					end
					if (s_q.idx == `RPB_IDX_OP) begin
						s_d.op = b;
					end else begin
						case (s_q.op)
							`RPB_OP_WRBUF: begin
								if (s_q.idx == `RPB_IDX_P1) begin
									s_d.acc_ptr = b;
								end else begin
									s_d.wr_pend = 1'b1;
									s_d.wr_addr = s_q.acc_ptr;
									s_d.wr_data = b;
									s_d.acc_ptr = inc8(s_q.acc_ptr);
								end
							end
							// reply is two bytes behind its request
							`RPB_OP_RDBUF: begin
								if (s_q.idx == `RPB_IDX_P1) begin
									s_d.pub = ram[b];
									s_d.acc_ptr = inc8(b);
								end else begin
									s_d.pub = ram[s_q.acc_ptr];
									s_d.acc_ptr = inc8(s_q.acc_ptr);
								end
							end
							// any offset accepted for either base
							`RPB_OP_SETBASE: begin
								if (s_q.idx == `RPB_IDX_P1) begin
									s_d.tx_base = b;
								end else if (s_q.idx == `RPB_IDX_P2) begin
									s_d.rx_base = b;
								end
							end
							`RPB_OP_PKTLEN: begin
								if (s_q.idx == `RPB_IDX_P1) begin
									s_d.plen = b;
								end
							end
							`RPB_OP_RXSTAT: begin
								if (s_q.idx == `RPB_IDX_P1) begin
									s_d.pub = s_q.last_len;
								end else if (s_q.idx == `RPB_IDX_P2) begin
									s_d.pub = s_q.last_start;
								end else begin
									s_d.pub = `RPB_ZERO8;
								end
							end
							default: begin
								s_d.pub = `RPB_ZERO8;
							end
						endcase
					end
				end
				// only write commands raise busy after the frame
				if (cs_rise && is_wr_op(s_d.op) && s_q.idx != `RPB_IDX_OP)
				begin
					s_d.busy_cnt = `RPB_BUSY_HOLD;
				end
			end
			default: begin
				s_d.mode = rpb_pkg::M_CLEAR;
			end
		endcase
		// full reset keeps only synchronisers, the pin watch and the output enable
		if (hrst_hit) begin
			keep = s_d;
			s_d = SYS_RST; // bases back to zero
			s_d.cs_s1 = keep.cs_s1;
			s_d.cs_s2 = keep.cs_s2;
			s_d.cs_s3 = keep.cs_s3;
			s_d.hr_s1 = keep.hr_s1;
			s_d.hr_s2 = keep.hr_s2;
			s_d.tg_s1 = keep.tg_s1;
			s_d.tg_s2 = keep.tg_s2;
			s_d.tg_s3 = keep.tg_s3;
			s_d.hrst_cnt = keep.hrst_cnt;
			s_d.hrst_done = 1'b1;
			s_d.oe_n = keep.oe_n;
		end
		// busy whenever not ready to take a command
		s_d.busy = !awake(s_d.mode) || (s_d.busy_cnt != 4'h0);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q <= SYS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// packet ram, no reset so it maps to a memory
	always_ff @(posedge sys_clk) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	// outputs straight from flops
	assign miso      = fa_q.sh[7];
	assign miso_oe_n = s_q.oe_n;
	assign busy      = s_q.busy;
	assign tx_valid  = s_q.tx_valid;
	assign tx_data   = s_q.tx_data;
	assign tx_done   = s_q.tx_done;
	assign mode_o    = s_q.mode;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	localparam int TSW_MAX = `RPB_TSW_CYC;
	logic awake_q;
	assign awake_q = awake(s_q.mode);

	sequence wr_frame_end;
		awake_q && !s_q.cs_s3 && s_q.cs_s2 && is_wr_op(s_q.op) &&
			s_q.idx != `RPB_IDX_OP && !mode_req.sleep && !hrst_hit;
	endsequence

	sequence rd_frame_end;
		awake_q && !s_q.cs_s3 && s_q.cs_s2 && !is_wr_op(s_q.op) &&
			s_q.busy_cnt == 4'h0;
	endsequence

	a_rx_single_load: assert property (
		awake_q && mode_req.rx_single && !mode_req.sleep &&
			!mode_req.stby && !mode_req.tx && !hrst_hit
		|=> s_q.rx_ptr == $past(s_q.rx_base))
		else $error("rx pointer not loaded from base");
	a_rx_cont_keep: assert property (
		awake_q && mode_req.rx_cont && !mode_req.rx_single &&
			!mode_req.sleep && !mode_req.stby && !mode_req.tx &&
			!rx_valid && !hrst_hit
		|=> s_q.rx_ptr == $past(s_q.rx_ptr))
		else $error("continuous rx pointer moved");
	a_tx_entry_load: assert property (
		awake_q && mode_req.tx && !mode_req.sleep && !mode_req.stby &&
			!hrst_hit
		|=> s_q.tx_ptr == $past(s_q.tx_base) && s_q.tx_cnt == 8'h00)
		else $error("tx pointer not loaded from base");
	a_tx_len_stop: assert property (
		s_q.mode == rpb_pkg::M_TX && tx_req && s_q.tx_cnt == s_q.plen
		|=> !s_q.tx_valid && $stable(s_q.tx_ptr))
		else $error("tx ran past payload length");
	a_rx_store: assert property (
		rx_wr |=> ram[$past(s_q.rx_ptr)] == $past(rx_data))
		else $error("received byte not stored");
	a_ptr_wrap: assert property (
		rx_wr && s_q.rx_ptr == `RPB_LAST8 && !hrst_hit
		|=> s_q.rx_ptr == 8'h00)
		else $error("rx pointer did not wrap");
	a_clear_zero: assert property (
		s_q.mode == rpb_pkg::M_CLEAR |-> ram_we && ram_wd == 8'h00)
		else $error("sleep entry did not clear ram");
	a_base_reset: assert property (
		hrst_hit |=> s_q.rx_base == 8'h00 && s_q.tx_base == 8'h00 &&
			s_q.mode == rpb_pkg::M_CLEAR)
		else $error("hard reset left bases set");
	a_busy_write: assert property (
		wr_frame_end |-> ##[1:TSW_MAX] s_q.busy)
		else $error("busy late after write command");
	a_busy_read: assert property (
		rd_frame_end ##1 awake_q |-> !s_q.busy)
		else $error("read command raised busy");
	a_busy_asleep: assert property (
		!awake_q |-> s_q.busy)
		else $error("busy low while not ready");
	a_sleep_wake: assert property (
		s_q.mode == rpb_pkg::M_SLEEP && s_q.cs_s3 && !s_q.cs_s2 &&
			!hrst_hit
		|=> s_q.mode == rpb_pkg::M_INIT ##1 s_q.busy[*2])
		else $error("chip select did not wake");
	a_miso_float: assert property (
		s_q.cs_s2 |=> miso_oe_n)
		else $error("miso driven outside frame");
endmodule

// *** test/rpb_host_model.sv ***
`timescale 1ns/1ns
// ****************************************************
// host side master of the serial link
// ****************************************************
module rpb_host_model (
	// host serial link
	output logic      sck,
	output logic      chip_select_n,
	output logic      mosi,
	input  wire logic miso
);
	// the link clock stands still low outside frames
	initial begin
		sck = 1'b0;
		chip_select_n = 1'b1;
		mosi = 1'b1;
	end

	// one frame of n bytes, msb first, 160 ns link period
	task automatic frame(input logic [7:0] msg [0:7], input int n,
			input bit wake, output logic [7:0] rep [0:7]);
		#17 chip_select_n = 1'b0;
		// a sleeping device needs its wake-up time first
		if (wake) #100000;
		else #200;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				mosi = msg[b][i];
				#80 sck = 1'b1;
				rep[b][i] = miso;
				#80 sck = 1'b0;
			end
		end
		#80 chip_select_n = 1'b1;
		// a released data line must not keep its last level
		mosi = ~mosi;
		#130;
	endtask
endmodule

// *** test/rpb_top_bench.sv ***
`timescale 1ns/1ns
module rpb_top_bench;
	// ****************************************************
	// signals
	// ****************************************************
	logic                   sys_clk, rst, sck, chip_select_n, mosi;
	logic                   miso, miso_oe_n, busy, hardware_reset_n;
	logic                   rx_valid, rx_end, tx_req, tx_valid, tx_done;
	logic [7:0]             rx_data, tx_data;
	rpb_pkg::rpb_mode_req_t mode_req;
	rpb_pkg::rpb_mode_t     mode_o;
	int                     mismatches, checks_done;
	logic [7:0]             msg [0:7];
	logic [7:0]             rep [0:7];

	// calibration shortened so wake and reset stay quick
	rpb_top #(.INIT_CYC(16'h0004)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .sck(sck),
		.chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n), .busy(busy),
		.hardware_reset_n(hardware_reset_n), .mode_req(mode_req),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_done(tx_done), .mode_o(mode_o));
	rpb_host_model i_host (.sck(sck), .chip_select_n(chip_select_n),
		.mosi(mosi), .miso(miso));

	always #50 sys_clk = ~sys_clk;

	// ****************************************************
	// helpers
	// ****************************************************
	task tick;
		@(posedge sys_clk);
		#1;
	endtask

	task report_and_stop;
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// bounded waits: a hang ends the run as a mismatch
	task wait_mode(input rpb_pkg::rpb_mode_t m);
		for (int i = 0; i < 3000 && mode_o !== m; i++)
			tick;
		chk("mode", 8'(m), 8'(mode_o));
		if (mode_o !== m)
			report_and_stop;
	endtask

	task wait_ready;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			tick;
		chk("busy low", 8'h00, 8'(busy));
		if (busy !== 1'b0)
			report_and_stop;
	endtask

	task m(input logic [47:0] v);
		for (int i = 0; i < 6; i++)
			msg[i] = v[47-8*i -: 8];
	endtask

	// a frame, then busy must rise only after write commands
	task send(input int n, input bit busy_exp);
		bit seen;
		seen = 1'b0;
		i_host.frame(msg, n, 1'b0, rep);
		for (int i = 0; i < 8; i++) begin
			if (busy === 1'b1)
				seen = 1'b1;
			tick;
		end
		chk("busy pulse", 8'(busy_exp), 8'(seen));
		chk("miso_oe_n idle", 8'h01, 8'(miso_oe_n));
		wait_ready;
	endtask

	task mreq(input logic [4:0] r);
		tick;
		mode_req = rpb_pkg::rpb_mode_req_t'(r);
		tick;
		mode_req = '0;
		tick;
	endtask

	task pull(input logic [7:0] e);
		logic [7:0] g;
		g = 8'hxx;
		tick;
		tx_req = 1'b1;
		tick;
		tx_req = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (tx_valid === 1'b1)
				g = tx_data;
			tick;
		end
		chk("tx byte", e, g);
	endtask

	task rxb(input logic [7:0] d, input logic last);
		tick;
		rx_valid = 1'b1;
		rx_data = d;
		rx_end = last;
		tick;
		rx_valid = 1'b0;
		rx_end = 1'b0;
	endtask

	task status(input logic [7:0] len, input logic [7:0] start);
		m(48'h4000_0000_0000);
		send(5, 1'b0);
		chk("status length", len, rep[3]);
		chk("status start", start, rep[4]);
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task t_reset;
		chk("busy in reset", 8'h01, 8'(busy));
		chk("mode clear", 8'(rpb_pkg::M_CLEAR), 8'(mode_o));
		wait_ready;
		chk("mode stby", 8'(rpb_pkg::M_STBY), 8'(mode_o));
	endtask

	// write across the top of the buffer and read it back
	task t_buf;
		m(48'h10FE_A1B2_C300);
		send(5, 1'b1);
		m(48'h20FE_0000_0000);
		send(6, 1'b0);
		chk("read 0xfe", 8'hA1, rep[3]);
		chk("read 0xff", 8'hB2, rep[4]);
		chk("read wrap", 8'hC3, rep[5]);
	endtask

	task t_tx;
		m(48'h5002_0000_0000);
		send(2, 1'b1);
		mreq(5'h04);
		pull(8'hC3);
		pull(8'h00);
		pull(8'hxx);
		chk("tx done", 8'h01, 8'(tx_done));
		mreq(5'h08);
		m(48'h30FE_1000_0000);
		send(3, 1'b1);
		mreq(5'h04);
		chk("tx done clear", 8'h00, 8'(tx_done));
		pull(8'hA1);
		pull(8'hB2);
		mreq(5'h08);
	endtask

	// single, continuous, single again; then a wrap past the top
	task t_rx;
		mreq(5'h02);
		chk("mode rx", 8'(rpb_pkg::M_RX), 8'(mode_o));
		rxb(8'h11, 1'b0);
		rxb(8'h22, 1'b0);
		rxb(8'h33, 1'b1);
		status(8'h03, 8'h10);
		mreq(5'h08);
		mreq(5'h01);
		rxb(8'h44, 1'b0);
		rxb(8'h55, 1'b1);
		status(8'h02, 8'h13);
		mreq(5'h08);
		mreq(5'h02);
		rxb(8'h66, 1'b1);
		status(8'h01, 8'h10);
		mreq(5'h08);
		m(48'h2010_0000_0000);
		send(8, 1'b0);
		for (int i = 0; i < 5; i++)
			chk("rx data", (i == 0) ? 8'h66 : 8'(8'h11 * (i + 1)),
				rep[3+i]);
		// receive base at the top: pointer wraps into the transmit area
		m(48'h3000_FF00_0000);
		send(3, 1'b1);
		mreq(5'h02);
		rxb(8'h77, 1'b0);
		rxb(8'h88, 1'b1);
		status(8'h02, 8'hFF);
		mreq(5'h04);
		pull(8'h88);
		mreq(5'h08);
	endtask

	task t_sleep;
		mreq(5'h10);
		wait_mode(rpb_pkg::M_SLEEP);
		chk("busy asleep", 8'h01, 8'(busy));
		// the waking frame itself carries a write after the wake-up wait
		m(48'h10FE_5C00_0000);
		i_host.frame(msg, 3, 1'b1, rep);
		wait_ready;
		chk("mode woken", 8'(rpb_pkg::M_STBY), 8'(mode_o));
		m(48'h20FE_0000_0000);
		send(6, 1'b0);
		chk("wake write", 8'h5C, rep[3]);
		chk("cleared", 8'h00, rep[4] | rep[5]);
	endtask

	task t_hrst;
		hardware_reset_n = 1'b0;
		repeat (1020) tick;
		chk("busy in hard reset", 8'h01, 8'(busy));
		hardware_reset_n = 1'b1;
		wait_ready;
		m(48'h1000_5A00_0000);
		send(3, 1'b1);
		m(48'h5001_0000_0000);
		send(2, 1'b1);
		mreq(5'h04);
		pull(8'h5A);
	endtask

	// ****************************************************
	// main sequence and watchdog
	// ****************************************************
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		hardware_reset_n = 1'b1;
		mode_req = '0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		tx_req = 1'b0;
		mismatches = 0;
		checks_done = 0;
		for (int i = 0; i < 8; i++)
			msg[i] = 8'h00;
		repeat (16) tick;
		rst = 1'b0;
		t_reset;
		t_buf;
		t_tx;
		t_rx;
		t_sleep;
		t_hrst;
		report_and_stop;
	end

	initial begin
		#9000000;
		mismatches++;
		report_and_stop;
	end
endmodule
